// file: verilog/acf_flags.sv
// alarm and condition flag logic: aggregates alarm classes, latches the new-alarm and horn
// flags, derives health, rotation, dead-line, mains-parallel and sync-check conditions
// assumes all inputs except the acknowledge button arrive on clk; the button is a pin
//
// Functional notes
// - class flag: class active or latched
// - any-alarm flag: any class set
// - warning flag: class one or two
// - shutdown flag: classes three to six
// - centralized flag: classes two to six
// - new alarm held until acknowledge
// - horn held until horn time elapses
// - constant false and true variables
// - voltage-ok and frequency-ok per source
// - system B health: voltage and frequency
// - auxiliary health: voltage and frequency
// - system A health: voltage and frequency
// - rotation flags only with three-phase measurement
// - dead flag below single dead maximum
// - mains parallel: mains, variable, breakers closed
// - sync condition: all enabled criteria met
// - sync relay: sync OR dead closure
// - mains release flag follows release
// - acknowledge condition lasts forty milliseconds
`timescale 1ns/100ps

module acf_flags #(
   parameter int ACK_LEN = acf_pkg::ACK_CYCLES,  // acknowledge length in cycles
   parameter int MS_LEN  = acf_pkg::MS_CYCLES    // cycles per horn timer millisecond
) (
   input  wire logic               clk,        // 100 MHz system clock
   input  wire logic               rst_n,      // synchronous reset, active low
   input  wire acf_pkg::acf_alarm_t alarmIn,   // alarm class states and triggers
   input  wire acf_pkg::acf_meas_t measIn,     // measurement comparator verdicts
   input  wire acf_pkg::acf_brk_t  brkIn,      // breaker feedback and sync criteria
   input  wire logic               ackButton,  // acknowledge push-button pin, asynchronous
   input  wire logic               extAck,     // external acknowledge pulse, on clk
   input  wire logic [7:0]         regAddr,    // register byte address
   input  wire logic [31:0]        regWdata,   // register write data
   input  wire logic               regWe,      // register write strobe
   input  wire logic               regRe,      // register read strobe
   output logic [31:0]             regRdata,   // read data, cycle after the strobe
   output acf_pkg::acf_flags_t     flagsOut    // registered condition variables
);
   import acf_pkg::*;

   localparam int ACK_W = $clog2(ACK_LEN + 1);  // acknowledge counter width
   localparam int MS_W  = $clog2(MS_LEN + 1);   // prescaler width

   // true when any class selected by sel has an active or latched alarm
   function automatic logic anyClass(input logic [5:0] act, input logic [5:0] sel);
      anyClass = |(act & sel);
   endfunction : anyClass

   // ------------------------------------------------------------------ registers
   logic [5:0]  syncMask_q;    // enabled phase-matching criteria
   logic [15:0] hornTime_q;    // horn reset time, ms
   logic [15:0] deadMax_q;     // dead-bus maximum voltage
   logic [31:0] regRdata_q;    // read data holding register

   // write decode, one per configuration register
   wire wrSyncMask = regWe && (regAddr == REG_SYNC_MASK);
   wire wrHornTime = regWe && (regAddr == REG_HORN_TIME);
   wire wrDeadMax  = regWe && (regAddr == REG_DEAD_MAX);

   // configuration registers; narrower fields take the low bits of the write
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         syncMask_q <= RST_SYNC_MASK;
         hornTime_q <= RST_HORN_TIME;
         deadMax_q  <= RST_DEAD_MAX;
      end else begin
         if (wrSyncMask) syncMask_q <= regWdata[5:0];
         if (wrHornTime) hornTime_q <= regWdata[15:0];
         if (wrDeadMax)  deadMax_q  <= regWdata[15:0];
      end
   end

   // read mux; unmapped addresses read zero
   acf_flags_t flags_q;  // registered flag vector
   logic [34:0] flagBits;
   assign flagBits = flags_q;
   logic [31:0] rdMux;
   assign rdMux = (regAddr == REG_SYNC_MASK) ? {26'h0000000, syncMask_q} :
                  (regAddr == REG_HORN_TIME) ? {16'h0000, hornTime_q} :
                  (regAddr == REG_DEAD_MAX)  ? {16'h0000, deadMax_q} :
                  (regAddr == REG_STAT_LO)   ? flagBits[31:0] :
                  (regAddr == REG_STAT_HI)   ? {29'h00000000, flagBits[34:32]} :
                  32'h00000000;

   // read data stands only in the cycle after the read strobe
   always_ff @(posedge clk) begin
      if (!rst_n) regRdata_q <= 32'h00000000;
      else        regRdata_q <= regRe ? rdMux : 32'h00000000;
   end
   assign regRdata = regRdata_q;

   // ------------------------------------------------------------ acknowledge
   // the button is a pin: two flops before anything looks at it
   logic ackS1_q;    // first synchroniser stage
   logic ackS2_q;    // second synchroniser stage
   logic ackPrev_q;  // previous synchronised level, for the edge
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ackS1_q   <= 1'b0;
         ackS2_q   <= 1'b0;
         ackPrev_q <= 1'b0;
      end else begin
         ackS1_q   <= ackButton;
         ackS2_q   <= ackS1_q;
         ackPrev_q <= ackS2_q;
      end
   end

   // a press or an external acknowledge; a held button acts once
   wire ackEvent = (ackS2_q && !ackPrev_q) || extAck;

   // acknowledge condition counter; a new event restarts the full length
   logic [ACK_W-1:0] ackCnt_q;
   logic [ACK_W-1:0] ackCnt_d;
   assign ackCnt_d = ackEvent ? ACK_W'(ACK_LEN) :
                     (ackCnt_q != '0) ? ackCnt_q - ACK_W'(1) : ackCnt_q;
   always_ff @(posedge clk) begin
      if (!rst_n) ackCnt_q <= '0;
      else        ackCnt_q <= ackCnt_d;
   end
   wire ackCond_d = (ackCnt_d != '0);

   // ------------------------------------------------------ new alarm and horn
   // class one alarms never raise the new-alarm flag or the horn
   wire newTrig = anyClass(alarmIn.trig, 6'h3E);

   // set wins over the acknowledge in the same cycle, so no trigger is lost
   logic newAlarm_q;
   wire  newAlarm_d = newTrig || (newAlarm_q && !ackEvent);

   // horn: ms prescaler plus remaining-time counter
   logic            hornOn_q;   // horn active
   logic [15:0]     hornMs_q;   // ms remaining
   logic [MS_W-1:0] msCnt_q;    // cycles into the current ms
   wire msTick = (msCnt_q == MS_W'(MS_LEN - 1));
   // a zero horn time would give no horn at all; that is what it means
   wire hornStart = newTrig && (hornTime_q != 16'h0000);
   wire hornEnd   = hornOn_q && msTick && (hornMs_q <= 16'h0001);

   logic            hornOn_d;
   logic [15:0]     hornMs_d;
   logic [MS_W-1:0] msCnt_d;
   // retrigger reloads the time; expiry ends the horn
   assign hornOn_d = hornStart || (hornOn_q && !hornEnd);
   assign hornMs_d = hornStart ? hornTime_q :
                     (hornOn_q && msTick) ? hornMs_q - 16'h0001 : hornMs_q;
   assign msCnt_d  = (hornStart || msTick || !hornOn_q) ? '0 : msCnt_q + MS_W'(1);

   // alarm state flops, all cleared by reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         newAlarm_q <= 1'b0;
         hornOn_q   <= 1'b0;
         hornMs_q   <= 16'h0000;
         msCnt_q    <= '0;
      end else begin
         newAlarm_q <= newAlarm_d;
         hornOn_q   <= hornOn_d;
         hornMs_q   <= hornMs_d;
         msCnt_q    <= msCnt_d;
      end
   end

   // ------------------------------------------------------- system conditions
   // dead detection: one shared threshold for every source
   logic [2:0] deadCmp;
   for (genvar s = 0; s < NUM_SRC; s++) begin : g_dead
      assign deadCmp[s] = (measIn.volt[s] < deadMax_q);
   end

   // mains parallel in either direction of mains and variable system
   wire mainsPar = ((brkIn.sysMains[0] && brkIn.sysVar[1]) ||
                    (brkIn.sysMains[1] && brkIn.sysVar[0])) &&
                   brkIn.breakerAClosed && brkIn.generatorBreakerClosed;

   // disabled criteria count as met; with none enabled the condition is true
   wire syncAll = &(brkIn.syncCrit | ~syncMask_q);

   // ------------------------------------------------------ next flag vector
   acf_flags_t flags_d;
   wire [5:0] classAct = alarmIn.active | alarmIn.latched;
   always_comb begin
      flags_d                   = '0;
      flags_d.classFlag         = classAct;
      flags_d.anyAlarm          = anyClass(classAct, 6'h3F);
      flags_d.warning           = anyClass(classAct, 6'h03);
      flags_d.shutdown          = anyClass(classAct, 6'h3C);
      flags_d.centralized       = anyClass(classAct, 6'h3E);
      flags_d.newAlarm          = newAlarm_d;
      flags_d.horn              = hornOn_d;
      flags_d.constFalse        = 1'b0;
      flags_d.constTrue         = 1'b1;
      flags_d.voltOk            = measIn.voltOk;
      flags_d.freqOk            = measIn.freqOk;
      flags_d.healthOk[SRC_B]   = measIn.voltOk[SRC_B] && measIn.freqOk[SRC_B];
      flags_d.healthOk[SRC_AUX] = measIn.voltOk[SRC_AUX] && measIn.freqOk[SRC_AUX];
      flags_d.healthOk[SRC_A]   = measIn.voltOk[SRC_A] && measIn.freqOk[SRC_A];
      // rotation only meaningful with a three-phase measurement
      flags_d.rotCw             = measIn.rotCw & measIn.threePh;
      flags_d.rotCcw            = measIn.rotCcw & measIn.threePh;
      flags_d.dead              = deadCmp;
      flags_d.mainsParallelFlag = mainsPar;
      flags_d.syncCond          = syncAll;
      // no dead-bus interlock here: the user must add one if needed
      flags_d.syncCheckRelay    = syncAll || brkIn.deadLineCloseFlag;
      flags_d.mainsReleaseFlag  = brkIn.mainsRelease;
      flags_d.ackCond           = ackCond_d;
   end

   // one register stage for every flag, rebuilt every cycle
   always_ff @(posedge clk) begin
      if (!rst_n) flags_q <= '0;
      else        flags_q <= flags_d;
   end
   assign flagsOut = flags_q;

   // ---------------------------------------------------------------- checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_CLASS_FLAG: assert property (
      rst_n |=> flagsOut.classFlag == $past(alarmIn.active | alarmIn.latched))
      else $error("class flag does not follow class state");

   AST_ANY_ALARM: assert property (
      rst_n |=> flagsOut.anyAlarm == ($past(classAct) != 6'h00))
      else $error("any-alarm flag wrong");

   AST_WARNING: assert property (
      rst_n |=> flagsOut.warning == ($past(classAct[1:0]) != 2'h0))
      else $error("warning flag wrong");

   AST_SHUTDOWN: assert property (
      rst_n |=> flagsOut.shutdown == ($past(classAct[5:2]) != 4'h0))
      else $error("shutdown flag wrong");

   AST_CENTRAL: assert property (
      rst_n |=> flagsOut.centralized == ($past(classAct[5:1]) != 5'h00))
      else $error("centralized flag wrong");

   AST_NEW_SET: assert property (
      rst_n && alarmIn.trig[5:1] != 5'h00 |=> flagsOut.newAlarm)
      else $error("new alarm not set by trigger");

   AST_NEW_HOLD: assert property (
      (rst_n && flagsOut.newAlarm && !ackEvent && alarmIn.trig == 6'h00) |=> flagsOut.newAlarm)
      else $error("new alarm dropped without acknowledge");

   AST_HORN_ON: assert property (
      (rst_n && alarmIn.trig[5:1] != 5'h00 && hornTime_q != 16'h0000) |=> hornOn_q &&
         hornMs_q ==
         $past(hornTime_q))
      else $error("horn not started with its time");

   AST_HORN_CLASS1: assert property (
      (!hornOn_q && alarmIn.trig[5:1] == 5'h00) |=> !hornOn_q)
      else $error("horn started without a new alarm above class one");

   AST_CONST: assert property (
      rst_n |=> !flagsOut.constFalse && flagsOut.constTrue)
      else $error("constant variables wrong");

   AST_HEALTH: assert property (
      rst_n |=> flagsOut.healthOk == $past(measIn.voltOk & measIn.freqOk))
      else $error("combined health flag wrong");

   AST_DEAD: assert property (
      rst_n |=> flagsOut.dead[SRC_A] == ($past(measIn.volt[SRC_A]) < $past(deadMax_q)))
      else $error("dead flag wrong");

   AST_SYNC_RELAY: assert property (
      rst_n |=> flagsOut.syncCheckRelay ==
         (flagsOut.syncCond || $past(brkIn.deadLineCloseFlag)))
      else $error("sync-check relay flag wrong");

   AST_ACK_LEN: assert property (
      rst_n && ackEvent |=> flagsOut.ackCond ##1 flagsOut.ackCond)
      else $error("acknowledge condition too short");

   AST_RESET: assert property (disable iff (1'b0)
      !rst_n |=> !hornOn_q && !newAlarm_q && hornMs_q == 16'h0000)
      else $error("reset did not clear alarm state");

endmodule : acf_flags

// file: verilog/acf_pkg.sv
// package of the alarm and condition flag block: offsets, reset values, timing, carriers
// assumes a single 100 MHz clock; all flag inputs except the acknowledge button are produced on that clock
package acf_pkg;

   // clock rate and timing figures
   localparam int          CLK_HZ        = 100_000_000;  // system clock rate
   localparam int          ACK_TIME_MS   = 40;           // acknowledge condition length, ms
   localparam int          ACK_CYCLES    = ACK_TIME_MS * (CLK_HZ / 1000);  // 4,000,000
   localparam int          MS_TIME       = 1;            // horn timer tick, ms
   localparam int          MS_CYCLES     = MS_TIME * (CLK_HZ / 1000);      // 100,000

   // sizes
   localparam int          NUM_CLASS     = 6;            // alarm classes one to six
   localparam int          NUM_SRC       = 3;            // system A, system B, auxiliary
   localparam int          SRC_A         = 0;            // source index of system A
   localparam int          SRC_B         = 1;            // source index of system B
   localparam int          SRC_AUX       = 2;            // source index of auxiliary input

   // register byte offsets
   localparam logic [7:0]  REG_SYNC_MASK = 8'h00;        // enabled phase-matching criteria
   localparam logic [7:0]  REG_HORN_TIME = 8'h04;        // horn reset time in ms
   localparam logic [7:0]  REG_DEAD_MAX  = 8'h08;        // dead-bus maximum voltage
   localparam logic [7:0]  REG_STAT_LO   = 8'h0C;        // flag vector bits 31..0
   localparam logic [7:0]  REG_STAT_HI   = 8'h10;        // flag vector bits 34..32

   // reset values
   localparam logic [5:0]  RST_SYNC_MASK = 6'h3F;        // all criteria enabled
   localparam logic [15:0] RST_HORN_TIME = 16'h03E8;     // horn reset time, ms
   localparam logic [15:0] RST_DEAD_MAX  = 16'h0064;     // dead-bus threshold, raw units

   // alarm source carrier
   typedef struct packed {
      logic [5:0] active;    // class has a currently active alarm
      logic [5:0] latched;   // class has a latched alarm
      logic [5:0] trig;      // one-cycle pulse: new alarm in class
   } acf_alarm_t;

   // measurement comparator carrier
   typedef struct packed {
      logic [2:0]       voltOk;   // voltage within operating range
      logic [2:0]       freqOk;   // frequency within operating range
      logic [2:0][15:0] volt;     // measured voltage per source
      logic [1:0]       rotCw;    // clockwise field seen, A and B
      logic [1:0]       rotCcw;   // counter-clockwise field seen, A and B
      logic [1:0]       threePh;  // three-phase measurement configured, A and B
   } acf_meas_t;

   // breaker feedback and sync carrier
   typedef struct packed {
      logic [1:0] sysMains;               // system A/B is mains connected
      logic [1:0] sysVar;                 // system A/B is variable
      logic       breakerAClosed;         // breaker_a reply closed
      logic       generatorBreakerClosed; // a generator_breaker of a relevant segment closed
      logic [5:0] syncCrit;               // individual phase-matching criteria met
      logic       deadLineCloseFlag;      // dead-bus closure conditions met
      logic       mainsRelease;           // mains breaker reconnection released
   } acf_brk_t;

   // condition variables handed to the equation engine (35 bits)
   typedef struct packed {
      logic       ackCond;           // acknowledge condition
      logic       mainsReleaseFlag;  // mains reconnection released
      logic       syncCheckRelay;    // sync or dead-bus closure
      logic       syncCond;          // all enabled criteria met
      logic       mainsParallelFlag; // generator parallel to mains
      logic [2:0] dead;              // source voltage below dead max
      logic [1:0] rotCcw;            // counter-clockwise field, A and B
      logic [1:0] rotCw;             // clockwise field, A and B
      logic [2:0] healthOk;          // voltage and frequency ok
      logic [2:0] freqOk;            // frequency ok
      logic [2:0] voltOk;            // voltage ok
      logic       constTrue;         // fixed one
      logic       constFalse;        // fixed zero
      logic       horn;              // horn output
      logic       newAlarm;          // unacknowledged new alarm
      logic       centralized;       // classes two to six
      logic       shutdown;          // classes three to six
      logic       warning;           // classes one and two
      logic       anyAlarm;          // any class
      logic [5:0] classFlag;         // per-class flag
   } acf_flags_t;

endpackage : acf_pkg

// file: test/acf_far_model.sv
// far-side model: alarm sources, measurement comparators and breaker feedback
// assumes the bench hands it three fresh random words just after each rising clock edge
`timescale 1ns/100ps

module acf_far_model (
   input  wire logic [31:0]    w0,        // raw word for the alarm sources
   input  wire logic [31:0]    w1,        // raw word for verdicts and breakers
   input  wire logic [31:0]    w2,        // raw word for the measured voltages
   output acf_pkg::acf_alarm_t alarmOut,  // alarm class states and pulses
   output acf_pkg::acf_meas_t  measOut,   // comparator verdicts
   output acf_pkg::acf_brk_t   brkOut     // breaker feedback and sync criteria
);
   import acf_pkg::*;

   // latched alarms sparser than active ones; new-alarm pulses are rare events
   assign alarmOut.active  = w0[5:0];
   assign alarmOut.latched = w0[11:6] & w0[17:12];
   assign alarmOut.trig    = (w0[31:26] == 6'h00) ? w0[23:18] : 6'h00;
   // comparator verdicts are plain levels
   assign measOut.voltOk   = w1[2:0];
   assign measOut.freqOk   = w1[5:3];
   // small voltages so that both sides of the dead threshold turn up often
   assign measOut.volt[0]  = {10'h000, w2[5:0]};
   assign measOut.volt[1]  = {10'h000, w2[11:6]};
   assign measOut.volt[2]  = {10'h000, w2[17:12]};
   // a real field never shows both turning directions at once
   assign measOut.rotCw    = w1[7:6];
   assign measOut.rotCcw   = w1[9:8] & ~w1[7:6];
   assign measOut.threePh  = w1[11:10];
   // breaker replies and plant topology
   assign brkOut.sysMains               = w1[13:12];
   assign brkOut.sysVar                 = w1[15:14];
   assign brkOut.breakerAClosed         = w1[16];
   assign brkOut.generatorBreakerClosed = w1[17];
   // criteria mostly met, so that all of them line up now and then
   assign brkOut.syncCrit               = w1[23:18] | w1[29:24];
   assign brkOut.deadLineCloseFlag      = w1[30];
   assign brkOut.mainsRelease           = w1[31];

endmodule : acf_far_model

// file: test/tb.sv
// self-checking bench of the alarm and condition flag block: random traffic, reference model
// assumes the far-side model shapes the random words; timers are shortened by parameters
`timescale 1ns/100ps

module tb;
   import acf_pkg::*;

   localparam int ACKL = 20;  // shortened acknowledge length
   localparam int MSL  = 10;  // shortened horn millisecond
   typedef struct {int due; logic [31:0] rd; acf_flags_t f;} acf_note_t;

   logic clk = 1'b0, rst_n = 1'b0, ackButton = 1'b0, extAck = 1'b0;  // clock, reset, acks
   logic regWe = 1'b0, regRe = 1'b0;                          // register strobes
   logic [7:0]  regAddr = 8'h00;                              // register address
   logic [31:0] regWdata = 32'h0000_0000, regRdata;           // register data
   logic [31:0] w0 = 32'h0, w1 = 32'h0, w2 = 32'h0;           // raw far-side words
   logic [31:0] seed = 32'h0000_95FA;                         // xorshift state
   logic [2:0]  op;                                           // register operation pick
   acf_alarm_t  alarmIn;                                      // alarm inputs
   acf_meas_t   measIn;                                       // measurement inputs
   acf_brk_t    brkIn;                                        // breaker inputs
   acf_flags_t  flagsOut;                                     // condition variables
   acf_note_t   q[$];                                         // expected results in order
   int          cyc = 0, nErrors = 0, nCompared = 0;          // cycle and result counters
   logic [5:0]  syncMaskM = RST_SYNC_MASK;                    // model of the criteria mask
   logic [15:0] hornTimeM = RST_HORN_TIME;                    // model of the horn time
   logic [15:0] deadMaxM = RST_DEAD_MAX;                      // model of the dead maximum
   logic        newM = 1'b0;                                  // model new-alarm latch
   acf_flags_t  prevF = '0;                                   // flags shown in this cycle
   int          ackRem = 0, hornRem = 0;                      // model timers
   logic [3:0]  btnH = 4'h0;                                  // button history, newest low
   logic [7:0]  adrTab [6] = '{REG_SYNC_MASK, REG_HORN_TIME, REG_DEAD_MAX, 8'h14,
                               REG_STAT_LO, REG_STAT_HI};     // addresses tried

   acf_far_model acf_far_model_i (.w0(w0), .w1(w1), .w2(w2), .alarmOut(alarmIn),
                                  .measOut(measIn), .brkOut(brkIn));
   acf_flags #(.ACK_LEN(ACKL), .MS_LEN(MSL)) acf_flags_i (.clk(clk), .rst_n(rst_n),
      .alarmIn(alarmIn), .measIn(measIn), .brkIn(brkIn), .ackButton(ackButton),
      .extAck(extAck), .regAddr(regAddr), .regWdata(regWdata), .regWe(regWe),
      .regRe(regRe), .regRdata(regRdata), .flagsOut(flagsOut));

   // free-running clock and a cycle count used to date the notes
   always #5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs

   task automatic check(input string what, input logic [34:0] seen, input logic [34:0] exp);
      nCompared++;
      if (seen !== exp) begin
         nErrors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic conclude();
      if (nErrors == 0 && nCompared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : conclude

   // reference for the cycle whose inputs are settled now; its result shows one edge later
   task automatic note();
      acf_note_t  n;
      acf_flags_t e;
      logic       ev;
      logic       trigNew;
      e = '0;
      n.rd = 32'h0000_0000;
      btnH = {btnH[2:0], ackButton};
      ev = extAck | (btnH[2] & ~btnH[3]);  // a held button counts once, after its synchroniser
      trigNew = |alarmIn.trig[5:1];        // class one never raises the new-alarm latch
      if (!rst_n) begin
         // reset clears latches and timers and puts the settings back to their reset values
         {newM, ackRem, hornRem, btnH} = '0;
         syncMaskM = RST_SYNC_MASK;
         hornTimeM = RST_HORN_TIME;
         deadMaxM = RST_DEAD_MAX;
      end else begin
         e.classFlag = alarmIn.active | alarmIn.latched;
         e.anyAlarm = |e.classFlag;
         e.warning = |e.classFlag[1:0];
         e.shutdown = |e.classFlag[5:2];
         e.centralized = |e.classFlag[5:1];
         newM = trigNew | (newM & ~ev);  // a fresh alarm wins over the acknowledge
         e.newAlarm = newM;
         if (trigNew) hornRem = int'(hornTimeM) * MSL;
         e.horn = (hornRem != 0);
         if (hornRem != 0) hornRem--;
         if (ev) ackRem = ACKL;
         e.ackCond = (ackRem != 0);
         if (ackRem != 0) ackRem--;
         e.constTrue = 1'b1;
         e.voltOk = measIn.voltOk;
         e.freqOk = measIn.freqOk;
         e.healthOk = measIn.voltOk & measIn.freqOk;
         e.rotCw = measIn.rotCw & measIn.threePh;
         e.rotCcw = measIn.rotCcw & measIn.threePh;
         for (int k = 0; k < NUM_SRC; k++) e.dead[k] = (measIn.volt[k] < deadMaxM);
         e.mainsParallelFlag = ((brkIn.sysMains[0] & brkIn.sysVar[1]) |
            (brkIn.sysMains[1] & brkIn.sysVar[0])) & brkIn.breakerAClosed &
            brkIn.generatorBreakerClosed;
         e.syncCond = &(brkIn.syncCrit | ~syncMaskM);
         e.syncCheckRelay = e.syncCond | brkIn.deadLineCloseFlag;
         e.mainsReleaseFlag = brkIn.mainsRelease;
         // unmapped places read as zero; writes land after this cycle's flags
         if (regRe && regAddr == REG_SYNC_MASK) n.rd = {26'h0, syncMaskM};
         if (regRe && regAddr == REG_HORN_TIME) n.rd = {16'h0, hornTimeM};
         if (regRe && regAddr == REG_DEAD_MAX) n.rd = {16'h0, deadMaxM};
         if (regRe && regAddr == REG_STAT_LO) n.rd = prevF[31:0];
         if (regRe && regAddr == REG_STAT_HI) n.rd = {29'h0, prevF[34:32]};
         if (regWe && regAddr == REG_SYNC_MASK) syncMaskM = regWdata[5:0];
         if (regWe && regAddr == REG_HORN_TIME) hornTimeM = regWdata[15:0];
         if (regWe && regAddr == REG_DEAD_MAX) deadMaxM = regWdata[15:0];
      end
      n.f = e;
      prevF = e;
      n.due = cyc + 1;
      q.push_back(n);
   endtask : note

   // stimulus: random words, acks, register traffic and one reset in mid-run
   initial begin
      repeat (2) @(posedge clk);
      for (int i = 0; i < 3000; i++) begin
         seed = xs(seed);
         w0 <= seed;
         seed = xs(seed);
         w1 <= seed;
         seed = xs(seed);
         w2 <= seed;
         extAck <= (seed[31:27] == 5'h00);
         ackButton <= ((i % 200) < 8);
         rst_n <= (i != 1500);
         op = (i == 1500) ? 3'd7 : seed[2:0];
         regWe <= (op == 3'd0);
         regRe <= (op == 3'd1);
         regAddr <= adrTab[seed[26:24] % 6];
         regWdata <= {seed[31:16], 10'h000, seed[13:9], 1'b1};  // never a zero horn time
         @(negedge clk);
         note();
         @(posedge clk);
      end
      repeat (2) @(negedge clk);
      conclude();
   end

   // watcher: every due note is held against the outputs
   always @(negedge clk) begin : watch
      acf_note_t  n;
      acf_flags_t f;
      acf_flags_t g;
      while (q.size() != 0 && q[0].due == cyc) begin
         n = q.pop_front();
         f = n.f;
         g = flagsOut;
         check("classFlag", 35'(g.classFlag), 35'(f.classFlag));
         check("anyAlarm", 35'(g.anyAlarm), 35'(f.anyAlarm));
         check("warning", 35'(g.warning), 35'(f.warning));
         check("shutdown", 35'(g.shutdown), 35'(f.shutdown));
         check("centralized", 35'(g.centralized), 35'(f.centralized));
         check("newAlarm", 35'(g.newAlarm), 35'(f.newAlarm));
         check("horn", 35'(g.horn), 35'(f.horn));
         check("constants", 35'({g.constTrue, g.constFalse}), 35'({f.constTrue, f.constFalse}));
         check("voltOk", 35'({g.voltOk, g.freqOk}), 35'({f.voltOk, f.freqOk}));
         check("healthOk", 35'(g.healthOk), 35'(f.healthOk));
         check("rotation", 35'({g.rotCw, g.rotCcw}), 35'({f.rotCw, f.rotCcw}));
         check("dead", 35'(g.dead), 35'(f.dead));
         check("mainsParallel", 35'(g.mainsParallelFlag), 35'(f.mainsParallelFlag));
         check("syncCond", 35'(g.syncCond), 35'(f.syncCond));
         check("syncCheckRelay", 35'(g.syncCheckRelay), 35'(f.syncCheckRelay));
         check("mainsRelease", 35'(g.mainsReleaseFlag), 35'(f.mainsReleaseFlag));
         check("ackCond", 35'(g.ackCond), 35'(f.ackCond));
         check("regRdata", 35'(regRdata), 35'(n.rd));
      end
   end

   // watchdog: the run needs about 30,000 ns
   initial begin
      #(100_000);
      nErrors++;
      conclude();
   end

endmodule : tb
